// *** rtl/sxp_host.sv ***
// Purpose: Controller end: frames words from a FIFO onto the serial link
// Assumes: Link clock derived from MCLK by a divider
// Notes:   One sixteen-bit word per frame, one chip in the chain
`timescale 1ns/1ns

module sxp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

module sxp_host
    import sxp_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Serial link
    sxp_link_if.ctl          LINK,
    // Expander reset and open-drain mode select hold
    input  wire logic        DEV_RESET,
    input  wire logic        HOLD_REQ,
    // Words to send
    input  wire logic [15:0] TX_DATA,
    input  wire logic        TX_VALID,
    output logic             TX_READY,
    // Port levels read back
    output logic      [15:0] RX_DATA,
    output logic             RX_VALID
);

    logic [15:0] f_data;
    logic        f_valid;
    logic        pop;
    logic        hold_pend_q;
    logic        take_hold;
    logic        rpin_q;
    logic        cs_n_q;
    logic        sclk_q;
    logic        din_q;
    logic        do_meta_q;
    logic        do_sync_q;
    logic        rx_en_q;
    logic [7:0]  tmr_q;
    logic [3:0]  idx_q;
    logic [15:0] word_q;
    logic [15:0] rx_q;
    sxp_ctl_state_type state_q;

    sxp_fifo #(
        .WIDTH (PORT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .in_data   (TX_DATA),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (pop)
    );

    // Nothing is taken while the expander is held in reset, so no word is lost
    assign take_hold = (state_q == CTL_IDLE_ST) & hold_pend_q & rpin_q;
    assign pop       = (state_q == CTL_IDLE_ST) & ~hold_pend_q & f_valid & rpin_q;

    assign LINK.cs_n        = cs_n_q;
    assign LINK.sclk        = sclk_q;
    assign LINK.din         = din_q;
    assign LINK.reset_n_pin = rpin_q;

    // Pending select hold, a new request wins over the clear
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            hold_pend_q <= 1'b0;
        end
        else if (HOLD_REQ)
        begin
            hold_pend_q <= 1'b1;
        end
        else if (take_hold)
        begin
            hold_pend_q <= 1'b0;
        end
    end

    // Expander reset pin and serial input synchroniser
    always_ff @(posedge MCLK)
    begin
        rpin_q    <= RST_N & ~DEV_RESET;
        do_meta_q <= LINK.dout;
        do_sync_q <= do_meta_q;
    end

    // Frame sequencer
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            state_q  <= CTL_IDLE_ST;
            cs_n_q   <= 1'b1;
            sclk_q   <= 1'b1;
            din_q    <= 1'b0;
            tmr_q    <= 8'h00;
            idx_q    <= 4'h0;
            word_q   <= 16'h0000;
            rx_q     <= 16'h0000;
            rx_en_q  <= 1'b0;
            RX_DATA  <= 16'h0000;
            RX_VALID <= 1'b0;
        end
        else
        begin
            RX_VALID <= 1'b0;
            if (tmr_q != 8'h00)
            begin
                tmr_q <= tmr_q - 8'h01;
            end
            case (state_q)
                CTL_IDLE_ST:
                begin
                    if (take_hold && rpin_q)
                    begin
                        cs_n_q  <= 1'b0;
                        tmr_q   <= SEL_HOLD_CYC;
                        rx_en_q <= 1'b0;
                        state_q <= CTL_HOLD_ST;
                    end
                    else if (pop && rpin_q)
                    begin
                        cs_n_q  <= 1'b0;
                        word_q  <= f_data;
                        tmr_q   <= SETUP_CYC;
                        rx_en_q <= 1'b1;
                        state_q <= CTL_SETUP_ST;
                    end
                end
                CTL_SETUP_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        sclk_q  <= 1'b0;
                        din_q   <= word_q[0];
                        idx_q   <= 4'h0;
                        tmr_q   <= HALF_CYC;
                        state_q <= CTL_LOW_ST;
                    end
                end
                CTL_LOW_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        sclk_q      <= 1'b1;
                        rx_q[idx_q] <= do_sync_q;
                        tmr_q       <= HALF_CYC;
                        state_q     <= CTL_HIGH_ST;
                    end
                end
                CTL_HIGH_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        tmr_q <= HALF_CYC;
                        if (idx_q == 4'hf)
                        begin
                            state_q <= CTL_TAIL_ST;
                        end
                        else
                        begin
                            sclk_q  <= 1'b0;
                            din_q   <= word_q[idx_q + 4'h1];
                            idx_q   <= idx_q + 4'h1;
                            state_q <= CTL_LOW_ST;
                        end
                    end
                end
                CTL_TAIL_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        cs_n_q  <= 1'b1;
                        tmr_q   <= GAP_CYC;
                        state_q <= CTL_GAP_ST;
                    end
                end
                CTL_HOLD_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        cs_n_q  <= 1'b1;
                        tmr_q   <= GAP_CYC;
                        state_q <= CTL_GAP_ST;
                    end
                end
                CTL_GAP_ST:
                begin
                    if (tmr_q == 8'h00)
                    begin
                        RX_DATA  <= rx_q;
                        RX_VALID <= rx_en_q;
                        state_q  <= CTL_IDLE_ST;
                    end
                end
                default:
                begin
                    state_q <= CTL_IDLE_ST;
                end
            endcase
        end
    end

endmodule

// *** pkg/sxp_pkg.sv ***
// Purpose: Shared constants for the serial I/O expander link and its controller
// Assumes: MCLK runs at 20 MHz on both ends
// Notes:   Select hold count is derived from a time in ns; other timing counts are given in cycles
package sxp_pkg;

    // Frame and port geometry
    localparam int          PORT_BITS   = 16;
    localparam logic [4:0]  FRAME_LAST  = 5'h0f;
    localparam logic [4:0]  FRAME_FULL  = 5'h10;

    // Reset values of the direction and output-state registers
    localparam logic [15:0] DIR_RESET   = 16'h0000;
    localparam logic [15:0] STATE_RESET = 16'hffff;

    // Clock and timing
    localparam int          MCLK_NS     = 50;
    localparam int          SEL_HOLD_NS = 1000;
    localparam logic [7:0]  SEL_HOLD_CYC =
        8'((SEL_HOLD_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0]  HALF_CYC    = 8'h04;
    localparam logic [7:0]  SETUP_CYC   = 8'h06;
    localparam logic [7:0]  GAP_CYC     = 8'h06;

    // Buffer geometry
    localparam int          FIFO_DEPTH  = 8;

    // Device mode states
    typedef enum logic [3:0] {
        DEV_RESET_ST = 4'b0001,
        DEV_INIT0_ST = 4'b0010,
        DEV_INIT1_ST = 4'b0100,
        DEV_DATA_ST  = 4'b1000
    } sxp_dev_state_type;

    // Controller states
    typedef enum logic [6:0] {
        CTL_IDLE_ST  = 7'b0000001,
        CTL_SETUP_ST = 7'b0000010,
        CTL_LOW_ST   = 7'b0000100,
        CTL_HIGH_ST  = 7'b0001000,
        CTL_TAIL_ST  = 7'b0010000,
        CTL_GAP_ST   = 7'b0100000,
        CTL_HOLD_ST  = 7'b1000000
    } sxp_ctl_state_type;

endpackage

// *** pkg/sxp_link_if.sv ***
// Purpose: Serial link between the controller and the expander
// Assumes: Clock idles high; select is active low
// Notes:   No bidirectional wires on the link itself
`timescale 1ns/1ns
interface sxp_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic reset_n_pin;

    // Expander end
    modport dev (
        input  cs_n,
        input  sclk,
        input  din,
        input  reset_n_pin,
        output dout
    );

    // Controller end
    modport ctl (
        output cs_n,
        output sclk,
        output din,
        output reset_n_pin,
        input  dout
    );
endinterface

// *** rtl/sxp_device.sv ***
// Purpose: Expander end: serial shift on the link clock, port registers on MCLK
// Assumes: Link clock stands still outside frames and idles high
// Notes:   Frame data is handed to MCLK after select rises and is stable
`timescale 1ns/1ns

// Summary of operation
// - Select low with reset high starts frame
// - First falling edge outputs port0_bit0 directly
// - First rising edge captures other fifteen pins
// - Falling edges shift captured bits, port0 first
// - Rising edges sample new data, same order
// - Select rise after sixteen clocks latches frame
// - Data-mode frames go to output-state register
// - Pins follow direction and output-state registers
// - Pins hold between frames, update per frame
// - Cascade frame is sixteen bits per chip
// - Reset: output high, direction 0, state 1
// - Direction and output-state registers per bit
// - Per-bit mode: first frame sets direction
// - Open-drain mode: held select fixes direction
module sxp_device
    import sxp_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Serial link
    sxp_link_if.dev          LINK,
    // Initial mode strap, high selects per-bit mode
    input  wire logic        INIT_MODE,
    // Port pins
    input  wire logic [15:0] PORT_I,
    output logic      [15:0] PORT_O,
    output logic      [15:0] PORT_OE
);

    // Link-clock domain
    logic [4:0]  bit_cnt_q;
    logic [15:0] shift_q;
    logic        full_q;
    logic        dout_q;

    // MCLK domain
    logic        cs_meta_q;
    logic        cs_sync_q;
    logic        cs_prev_q;
    logic        rp_meta_q;
    logic        rp_sync_q;
    logic        mode_meta_q;
    logic        mode_sync_q;
    logic [15:0] pin_meta_q;
    logic [15:0] pin_sync_q;
    logic [15:0] snap_q;
    logic [15:0] dir_q;
    logic [15:0] ostate_q;
    logic [7:0]  hold_cnt_q;
    logic        hold_done_q;
    logic        cs_rise;
    logic        frame_ok;
    sxp_dev_state_type state_q;

    // Bit counter, cleared whenever select is high
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n)
    begin
        if (LINK.cs_n)
        begin
            bit_cnt_q <= 5'h00;
        end
        else if (bit_cnt_q != FRAME_FULL)
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Shift register: input on rising edges
    always_ff @(posedge LINK.sclk)
    begin
        if (bit_cnt_q == 5'h00)
        begin
            shift_q <= {LINK.din, snap_q[15:1]};
        end
        else
        begin
            shift_q <= {LINK.din, shift_q[15:1]};
        end
    end

    // Frame complete after the sixteenth rising edge
    always_ff @(posedge LINK.sclk)
    begin
        full_q <= (bit_cnt_q >= FRAME_LAST);
    end

    // Serial output on falling edges
    always_ff @(negedge LINK.sclk or posedge LINK.cs_n)
    begin
        if (LINK.cs_n)
        begin
            dout_q <= 1'b1;
        end
        else if (!LINK.reset_n_pin)
        begin
            dout_q <= 1'b1;
        end
        else if (bit_cnt_q == 5'h00)
        begin
            dout_q <= snap_q[0];
        end
        else
        begin
            dout_q <= shift_q[0];
        end
    end

    assign LINK.dout = dout_q;

    // Synchronisers for select, reset pin, strap and port pins
    always_ff @(posedge MCLK)
    begin
        cs_meta_q   <= LINK.cs_n;
        cs_sync_q   <= cs_meta_q;
        cs_prev_q   <= cs_sync_q;
        rp_meta_q   <= LINK.reset_n_pin;
        rp_sync_q   <= rp_meta_q;
        mode_meta_q <= INIT_MODE;
        mode_sync_q <= mode_meta_q;
        pin_meta_q  <= PORT_I;
        pin_sync_q  <= pin_meta_q;
    end

    // Port snapshot frozen while select is low
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            snap_q <= 16'h0000;
        end
        else if (cs_sync_q)
        begin
            snap_q <= pin_sync_q;
        end
    end

    assign cs_rise  = cs_sync_q & ~cs_prev_q;
    assign frame_ok = cs_rise & full_q & rp_sync_q;

    // Select low hold timer for the open-drain initial mode
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || cs_sync_q || state_q != DEV_INIT0_ST)
        begin
            hold_cnt_q  <= 8'h00;
            hold_done_q <= 1'b0;
        end
        else if (hold_cnt_q != SEL_HOLD_CYC)
        begin
            hold_cnt_q  <= hold_cnt_q + 8'h01;
        end
        else
        begin
            hold_done_q <= 1'b1;
        end
    end

    // Mode state and the two port registers
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || !rp_sync_q)
        begin
            state_q  <= DEV_RESET_ST;
            dir_q    <= DIR_RESET;
            ostate_q <= STATE_RESET;
        end
        else
        begin
            case (state_q)
                DEV_RESET_ST:
                begin
                    if (mode_sync_q)
                    begin
                        state_q <= DEV_INIT1_ST;
                    end
                    else
                    begin
                        state_q <= DEV_INIT0_ST;
                    end
                end
                DEV_INIT0_ST:
                begin
                    if (hold_done_q && cs_sync_q)
                    begin
                        dir_q   <= DIR_RESET;
                        state_q <= DEV_DATA_ST;
                    end
                end
                DEV_INIT1_ST:
                begin
                    if (frame_ok)
                    begin
                        dir_q   <= shift_q;
                        state_q <= DEV_DATA_ST;
                    end
                end
                DEV_DATA_ST:
                begin
                    if (frame_ok)
                    begin
                        ostate_q <= shift_q;
                    end
                end
                default:
                begin
                    state_q <= DEV_RESET_ST;
                end
            endcase
        end
    end

    // Pin drivers: direction 1 drives level, 0 is open drain
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            PORT_O  <= 16'h0000;
            PORT_OE <= 16'h0000;
        end
        else
        begin
            PORT_O  <= dir_q & ostate_q;
            PORT_OE <= dir_q | ~ostate_q;
        end
    end

endmodule

// *** tb/sxp_monitor.sv ***
// Purpose: Checker for the serial link between host and expander
// Assumes: All link signals change just after MCLK edges
// Notes:   Takes the interface signals as plain inputs
`timescale 1ns/1ns
module sxp_monitor
    import sxp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic reset_n_pin
);
    logic       sclk_q;
    logic [4:0] rise_cnt_q;
    logic [7:0] low_cnt_q;

    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    // Previous link clock level
    always_ff @(posedge MCLK)
    begin
        sclk_q <= sclk;
    end

    // Link clock rises within the current frame
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || cs_n)
            rise_cnt_q <= 5'h00;
        else if (sclk && !sclk_q)
            rise_cnt_q <= rise_cnt_q + 5'h01;
    end

    // Cycles with select low
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || cs_n)
            low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hff)
            low_cnt_q <= low_cnt_q + 8'h01;
    end

    dout_idle_high_a: assert property (cs_n && $past(cs_n) |-> dout)
        else $error("dout not high while select is high");
    sclk_idle_high_a: assert property (cs_n |-> sclk)
        else $error("link clock not idle high outside a frame");
    select_setup_a: assert property ($fell(sclk) |-> !cs_n && !$past(cs_n, 3))
        else $error("link clock fell too soon after select");
    half_period_a: assert property ($fell(sclk) |-> !sclk[*5] ##1 sclk)
        else $error("link clock low phase not five cycles");
    frame_count_a: assert property ($rose(cs_n) |-> rise_cnt_q == FRAME_FULL
        || rise_cnt_q == 5'h00)
        else $error("select rose after a partial frame");
    select_after_last_a: assert property ($rose(sclk) && rise_cnt_q == FRAME_LAST
        |-> sclk[*8] ##[1:3] cs_n)
        else $error("select not raised after sixteenth rise");
    din_on_fall_a: assert property (!cs_n && !$past(cs_n) && $changed(din)
        |-> $fell(sclk))
        else $error("din changed away from a falling link clock");
    dout_on_fall_a: assert property (!cs_n && !$past(cs_n) && $changed(dout)
        |-> $fell(sclk))
        else $error("dout changed away from a falling link clock");
    reset_no_frame_a: assert property (!reset_n_pin |-> cs_n)
        else $error("frame started with reset pin low");
    hold_length_a: assert property ($rose(cs_n) && rise_cnt_q == 5'h00
        |-> low_cnt_q == SEL_HOLD_CYC + 8'h01)
        else $error("select hold length wrong");

    cover property ($rose(cs_n) && rise_cnt_q == FRAME_FULL);
    cover property ($rose(cs_n) && rise_cnt_q == 5'h00);
    cover property ($fell(reset_n_pin));
    cover property (!cs_n && !dout);
endmodule

// *** tb/testbench.sv ***
// Purpose: Host and expander joined back to back, plus a bench-driven link
// Assumes: MCLK period 50 ns; second link clock period 48 ns made here
// Notes:   Host and first expander inputs change on the falling edge of MCLK
`timescale 1ns/1ns
module testbench
    import sxp_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        dev_reset = 1'b0;
    logic        hold_req = 1'b0;
    logic        init_mode = 1'b1;
    logic [15:0] tx_data = 16'h0000;
    logic        tx_valid = 1'b0;
    logic        tx_ready;
    logic [15:0] rx_data;
    logic        rx_valid;
    logic [15:0] port_i = 16'h0000;
    logic [15:0] port_o;
    logic [15:0] port_oe;
    logic [15:0] port_o2;
    logic [15:0] port_oe2;
    int          mismatches = 0;
    int          samples_checked = 0;

    sxp_link_if link ();
    sxp_link_if link2 ();

    always #25 mclk = ~mclk;

    sxp_host sxp_host_inst (
        .MCLK (mclk), .RST_N (rst_n), .LINK (link.ctl),
        .DEV_RESET (dev_reset), .HOLD_REQ (hold_req),
        .TX_DATA (tx_data), .TX_VALID (tx_valid), .TX_READY (tx_ready),
        .RX_DATA (rx_data), .RX_VALID (rx_valid)
    );
    sxp_device sxp_device_inst (
        .MCLK (mclk), .RST_N (rst_n), .LINK (link.dev), .INIT_MODE (init_mode),
        .PORT_I (port_i), .PORT_O (port_o), .PORT_OE (port_oe)
    );
    sxp_device sxp_device_inst_2 (
        .MCLK (mclk), .RST_N (rst_n), .LINK (link2.dev), .INIT_MODE (1'b1),
        .PORT_I (16'h1234), .PORT_O (port_o2), .PORT_OE (port_oe2)
    );
    sxp_monitor sxp_monitor_inst (
        .MCLK (mclk), .RST_N (rst_n), .cs_n (link.cs_n), .sclk (link.sclk),
        .din (link.din), .dout (link.dout), .reset_n_pin (link.reset_n_pin)
    );

    task automatic print_verdict;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fail_wait(input string what);
        mismatches++;
        $display("wrong value %s expected done seen timeout", what);
        print_verdict();
    endtask

    // One word through the FIFO, then the read-back and the pins
    task automatic frame(input logic [15:0] w, pins, oe, o);
        int n;
        port_i = pins;
        @(negedge mclk);
        for (n = 0; n < 2000 && tx_ready !== 1'b1; n++)
            @(negedge mclk);
        if (n == 2000)
            fail_wait("tx_ready");
        tx_data = w;
        tx_valid = 1'b1;
        @(negedge mclk);
        tx_valid = 1'b0;
        for (n = 0; n < 2000 && rx_valid !== 1'b1; n++)
            @(negedge mclk);
        if (n == 2000)
            fail_wait("rx_valid");
        check("rx_data", rx_data, pins);
        repeat (2) @(negedge mclk);
        check("port_oe", port_oe, oe);
        check("port_o", port_o, o);
    endtask

    // Frame on the second link, clock made here, dout sampled before each rise
    task automatic link2_frame(input int nclk, input logic [31:0] w, output logic [31:0] seen);
        int i;
        seen = 32'h00000000;
        link2.cs_n = 1'b0;
        #200;
        for (i = 0; i < nclk; i++)
        begin
            link2.sclk = 1'b0;
            link2.din = w[i];
            #24;
            seen[i] = link2.dout;
            link2.sclk = 1'b1;
            #24;
        end
        #100;
        link2.cs_n = 1'b1;
        link2.din = ~link2.din;
        repeat (10) @(negedge mclk);
    endtask

    task automatic t_reset;
        check("port_oe", port_oe, 16'h0000);
        check("port_o", port_o, 16'h0000);
        check("dout", {15'h0000, link.dout}, 16'h0001);
    endtask

    task automatic t_frames;
        frame(16'h00ff, 16'ha5c3, 16'h00ff, 16'h00ff);
        frame(16'h0f0f, 16'h5a3c, 16'hf0ff, 16'h000f);
        port_i = 16'hffff;
        repeat (60) @(negedge mclk);
        check("port_oe", port_oe, 16'hf0ff);
        check("port_o", port_o, 16'h000f);
    endtask

    // Fill the FIFO until refused, then drain it frame by frame
    task automatic t_burst;
        int n;
        int got;
        int k;
        logic [15:0] w;
        n = 0;
        got = 0;
        port_i = 16'h8001;
        @(negedge mclk);
        while (tx_ready === 1'b1 && n < 12)
        begin
            tx_data = {n[7:0], ~n[7:0]};
            tx_valid = 1'b1;
            n++;
            @(negedge mclk);
        end
        tx_valid = 1'b0;
        check("tx_ready", {15'h0000, tx_ready}, 16'h0000);
        for (k = 0; k < 3000 && got < n; k++)
        begin
            @(negedge mclk);
            if (rx_valid === 1'b1)
            begin
                got++;
                check("rx_data", rx_data, 16'h8001);
            end
        end
        if (got < n)
            fail_wait("frames");
        repeat (2) @(negedge mclk);
        k = n - 1;
        w = {k[7:0], ~k[7:0]};
        check("port_oe", port_oe, 16'h00ff | ~w);
        check("port_o", port_o, 16'h00ff & w);
    endtask

    task automatic t_open_drain;
        dev_reset = 1'b1;
        init_mode = 1'b0;
        repeat (8) @(negedge mclk);
        check("reset_pin", {15'h0000, link.reset_n_pin}, 16'h0000);
        check("port_oe", port_oe, 16'h0000);
        dev_reset = 1'b0;
        repeat (8) @(negedge mclk);
        hold_req = 1'b1;
        @(negedge mclk);
        hold_req = 1'b0;
        repeat (40) @(negedge mclk);
        frame(16'h00f0, 16'h3c3c, 16'hff0f, 16'h0000);
    endtask

    task automatic t_link2;
        logic [31:0] seen;
        link2.reset_n_pin = 1'b1;
        repeat (4) @(negedge mclk);
        link2_frame(8, 32'h00000f0f, seen);
        check("port_oe2", port_oe2, 16'h0000);
        link2_frame(16, 32'h00000f0f, seen);
        check("dout2", seen[15:0], 16'h1234);
        check("port_oe2", port_oe2, 16'h0f0f);
        check("port_o2", port_o2, 16'h0f0f);
        // Two-chip chain length: first group passes out after sixteen clocks
        link2_frame(32, 32'h00ffc3a5, seen);
        check("dout2_pass", seen[31:16], 16'hc3a5);
        check("dout2_snap", seen[15:0], 16'h1234);
        check("port_oe2", port_oe2, 16'hff0f);
        check("port_o2", port_o2, 16'h000f);
    endtask

    initial
    begin
        link2.cs_n = 1'b0;
        link2.sclk = 1'b1;
        link2.din = 1'b0;
        link2.reset_n_pin = 1'b0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        // Select rise clears the second link's counter and sets its output high
        link2.cs_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_frames();
        t_burst();
        t_open_drain();
        t_link2();
        print_verdict();
    end
endmodule
